// ===== wwdr_params.svh
`ifndef WWDR_PARAMS_SVH
`define WWDR_PARAMS_SVH

// Register offsets (byte addresses)
`define WWDR_OFF_RELOAD 8'h00
`define WWDR_OFF_CTRL 8'h04
`define WWDR_OFF_STATUS 8'h08
`define WWDR_OFF_COUNT 8'h0C
`define WWDR_OFF_MASK 8'h10

// Reload key and counter values
`define WWDR_RELOAD_KEY 32'h00005AA5
`define WWDR_CNT_TOP 6'h3F
`define WWDR_CNT_ZERO 6'h00
`define WWDR_CNT_LAST 6'h01

// Control reset value and field positions
`define WWDR_CTRL_RESET 32'h003F0800
`define WWDR_CTRL_EN_BIT 0
`define WWDR_CTRL_IRQEN_BIT 1
`define WWDR_CTRL_PSC_LSB 8
`define WWDR_CTRL_PSC_MSB 11
`define WWDR_CTRL_CMP_LSB 16
`define WWDR_CTRL_CMP_MSB 21
`define WWDR_CTRL_DBG_BIT 31

// Status and mask bit positions
`define WWDR_ST_IRQ_BIT 0
`define WWDR_ST_CMP_BIT 2
`define WWDR_ST_MASK 3'h5

// Watchdog clocks from key write to counter reload
`define WWDR_RELOAD_SYNC 2'h3

`endif

// ===== wwdr_pkg.sv
package wwdr_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } wwdr_bus_req_t;

   typedef struct packed {
      logic debug_halt_disable;
      logic [5:0] window_compare;
      logic [3:0] prescale_select;
      logic irq_enable;
      logic counter_enable;
   } wwdr_ctrl_t;

endpackage

// ===== wwdr_window_watchdog_regs.sv
// Overview of operation
// - Only the key value written to reload_key restarts the counter at 0x3F.
// - Key written while counter_enable is set and counter above compare raises system reset request immediately.
// - With debug_halt_disable 0, counter freezes while the debugger halts the CPU.
// - With debug_halt_disable 1, counter keeps decrementing during debugger halt.
// - Six-bit window_compare field sets the upper limit of the reload window.
// - Prescale_select sets watchdog clocks per counter step; timeout is prescale times 63.
// - When enabled, counter steps from 0x3F toward 0 once per prescaled period.
// - window_control accepts only its first write after reset; later writes ignored.
// - Counter equal to compare sets compare flag, and irq flag if enabled.
// - A valid key reloads the counter three watchdog clocks after the write.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "wwdr_params.svh"

module wwdr_window_watchdog_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire wwdr_pkg::wwdr_bus_req_t bus_req_i,
   output logic [31:0] rdata_o,
   // Watchdog clock tick and debugger halt
   input wire logic wdog_tick_i,
   input wire logic cpu_halted_i,
   // System outputs
   output logic irq_o,
   output logic sys_reset_req_o
);

   function automatic logic hit(input wwdr_pkg::wwdr_bus_req_t req, input logic [7:0] off);
      hit = (req.addr == off);
   endfunction

   // Reset and the one allowed write unpack a word the same way
   function automatic wwdr_pkg::wwdr_ctrl_t ctrl_from(input logic [31:0] w);
      wwdr_pkg::wwdr_ctrl_t c;
      c.debug_halt_disable = w[`WWDR_CTRL_DBG_BIT];
      c.window_compare = w[`WWDR_CTRL_CMP_MSB:`WWDR_CTRL_CMP_LSB];
      c.prescale_select = w[`WWDR_CTRL_PSC_MSB:`WWDR_CTRL_PSC_LSB];
      c.irq_enable = w[`WWDR_CTRL_IRQEN_BIT];
      c.counter_enable = w[`WWDR_CTRL_EN_BIT];
      ctrl_from = c;
   endfunction

   // Prescaler period minus one for each select code
   function automatic logic [10:0] psc_last(input logic [3:0] code);
      case (code)
         4'h0: psc_last = 11'h000;
         4'h1: psc_last = 11'h001;
         4'h2: psc_last = 11'h003;
         4'h3: psc_last = 11'h007;
         4'h4: psc_last = 11'h00F;
         4'h5: psc_last = 11'h01F;
         4'h6: psc_last = 11'h03F;
         4'h7: psc_last = 11'h07F;
         4'h8: psc_last = 11'h0BF;
         4'h9: psc_last = 11'h0FF;
         4'hA: psc_last = 11'h17F;
         4'hB: psc_last = 11'h1FF;
         4'hC: psc_last = 11'h2FF;
         4'hD: psc_last = 11'h3FF;
         4'hE: psc_last = 11'h5FF;
         default: psc_last = 11'h7FF;
      endcase
   endfunction

   wwdr_pkg::wwdr_ctrl_t ctrl_reg;
   logic ctrl_locked_reg;
   logic [5:0] cnt_reg;
   logic [10:0] psc_cnt_reg;
   logic pend_reg;
   logic [1:0] sync_cnt_reg;
   logic [2:0] status_reg;
   logic [2:0] status_next;
   logic [2:0] mask_reg;
   logic [2:0] mask_next;
   logic [31:0] rdata_reg;
   logic irq_reg;
   logic rst_req_reg;

   logic wr_reload;
   logic wr_ctrl;
   logic key_ok;
   logic frozen;
   logic psc_wrap;
   logic step;
   logic reload_now;
   logic in_window;
   logic key_accept;
   logic key_early;
   logic hit_cmp;
   logic [2:0] ev_set;

   assign wr_reload = bus_req_i.we && hit(bus_req_i, `WWDR_OFF_RELOAD);
   assign wr_ctrl = bus_req_i.we && hit(bus_req_i, `WWDR_OFF_CTRL);
   assign key_ok = wr_reload && (bus_req_i.wdata == `WWDR_RELOAD_KEY);
   assign frozen = cpu_halted_i && !ctrl_reg.debug_halt_disable;
   assign psc_wrap = (psc_cnt_reg == psc_last(ctrl_reg.prescale_select));
   assign reload_now = pend_reg && wdog_tick_i
      && (sync_cnt_reg == (`WWDR_RELOAD_SYNC - 2'h1));
   assign step = ctrl_reg.counter_enable && wdog_tick_i && !frozen && psc_wrap
      && !reload_now && (cnt_reg != `WWDR_CNT_ZERO);
   assign in_window = (cnt_reg <= ctrl_reg.window_compare);
   assign key_accept = key_ok && ctrl_reg.counter_enable && in_window && !pend_reg;
   // A key during a pending reload is still window-checked, so it cannot dodge a reset
   assign key_early = key_ok && ctrl_reg.counter_enable && !in_window;
   assign hit_cmp = step && ((cnt_reg - `WWDR_CNT_LAST) == ctrl_reg.window_compare);

   // Control register: write once, then locked until chip reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= ctrl_from(`WWDR_CTRL_RESET);
         ctrl_locked_reg <= 1'b0;
      end else if (wr_ctrl && !ctrl_locked_reg) begin
         ctrl_reg <= ctrl_from(bus_req_i.wdata);
         ctrl_locked_reg <= 1'b1;
      end
   end

   // Prescaler: restarts with each reload so a fresh period follows it
   always_ff @(posedge clk_i) begin
      if (rst_i || reload_now) begin
         psc_cnt_reg <= 11'h000;
      end else if (ctrl_reg.counter_enable && wdog_tick_i && !frozen) begin
         psc_cnt_reg <= psc_wrap ? 11'h000 : psc_cnt_reg + 11'h001;
      end
   end

   // Down counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= `WWDR_CNT_TOP;
      end else if (reload_now) begin
         cnt_reg <= `WWDR_CNT_TOP;
      end else if (step) begin
         cnt_reg <= cnt_reg - `WWDR_CNT_LAST;
      end
   end

   // Reload sync; a second key during the wait adds nothing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg <= 1'b0;
         sync_cnt_reg <= 2'h0;
      end else if (key_accept) begin
         pend_reg <= 1'b1;
         sync_cnt_reg <= 2'h0;
      end else if (reload_now) begin
         pend_reg <= 1'b0;
         sync_cnt_reg <= 2'h0;
      end else if (pend_reg && wdog_tick_i) begin
         sync_cnt_reg <= sync_cnt_reg + 2'h1;
      end
   end

   // Reset request holds until chip reset clears it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_req_reg <= 1'b0;
      end else if (key_early) begin
         rst_req_reg <= 1'b1;
      end else if (step && (cnt_reg == `WWDR_CNT_LAST)) begin
         rst_req_reg <= 1'b1;
      end
   end

   // Status flags: set wins over a write-one clear in the same cycle
   always_comb begin
      ev_set = 3'h0;
      ev_set[`WWDR_ST_CMP_BIT] = hit_cmp;
      ev_set[`WWDR_ST_IRQ_BIT] = hit_cmp && ctrl_reg.irq_enable;
      status_next = status_reg;
      if (bus_req_i.we && hit(bus_req_i, `WWDR_OFF_STATUS)) begin
         status_next = status_reg & ~bus_req_i.wdata[2:0];
      end
      status_next = (status_next | ev_set) & `WWDR_ST_MASK;
      mask_next = mask_reg;
      if (bus_req_i.we && hit(bus_req_i, `WWDR_OFF_MASK)) begin
         mask_next = bus_req_i.wdata[2:0] & `WWDR_ST_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg <= 3'h0;
         mask_reg <= 3'h0;
         irq_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         mask_reg <= mask_next;
         irq_reg <= |(status_next & mask_next);
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i || !bus_req_i.re) begin
         rdata_reg <= 32'h00000000;
      end else begin
         case (bus_req_i.addr)
            `WWDR_OFF_CTRL: rdata_reg <= {ctrl_reg.debug_halt_disable, 9'h000,
               ctrl_reg.window_compare, 4'h0, ctrl_reg.prescale_select, 6'h00,
               ctrl_reg.irq_enable, ctrl_reg.counter_enable};
            `WWDR_OFF_STATUS: rdata_reg <= {29'h00000000, status_reg};
            `WWDR_OFF_COUNT: rdata_reg <= {26'h0000000, cnt_reg};
            `WWDR_OFF_MASK: rdata_reg <= {29'h00000000, mask_reg};
            default: rdata_reg <= 32'h00000000;
         endcase
      end
   end

   assign rdata_o = rdata_reg;
   assign irq_o = irq_reg;
   assign sys_reset_req_o = rst_req_reg;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_bad_key_ignored: assert property (
      (wr_reload && bus_req_i.wdata != `WWDR_RELOAD_KEY && !pend_reg) |=> !pend_reg)
      else $error("Wrong key started a reload");

   a_key_in_window: assert property (
      (key_ok && ctrl_reg.counter_enable && cnt_reg <= ctrl_reg.window_compare && !pend_reg)
      |=> pend_reg && !sys_reset_req_o)
      else $error("In-window key not accepted");

   a_early_key_reset: assert property (
      (key_ok && ctrl_reg.counter_enable && cnt_reg > ctrl_reg.window_compare)
      |=> sys_reset_req_o)
      else $error("Early key did not request reset");

   a_halt_freeze: assert property (
      (cpu_halted_i && !ctrl_reg.debug_halt_disable && !reload_now)
      |=> (cnt_reg == $past(cnt_reg)) && (psc_cnt_reg == $past(psc_cnt_reg)))
      else $error("Counter moved during debugger halt");

   a_halt_runs: assert property (
      (cpu_halted_i && ctrl_reg.debug_halt_disable && ctrl_reg.counter_enable && wdog_tick_i
       && psc_wrap && !reload_now && cnt_reg != `WWDR_CNT_ZERO)
      |=> cnt_reg == $past(cnt_reg) - `WWDR_CNT_LAST)
      else $error("Counter stopped during halt with disable set");

   a_prescale_bound: assert property (
      psc_cnt_reg <= psc_last(ctrl_reg.prescale_select))
      else $error("Prescaler beyond its period");

   a_step_once: assert property (
      (ctrl_reg.counter_enable && !frozen && wdog_tick_i && !psc_wrap && !reload_now)
      |=> cnt_reg == $past(cnt_reg))
      else $error("Counter stepped before prescale period ended");

   a_ctrl_locked: assert property (
      ctrl_locked_reg |=> $stable(ctrl_reg) && ctrl_locked_reg)
      else $error("Locked control register changed");

   a_cmp_flags: assert property (
      hit_cmp |=> status_reg[`WWDR_ST_CMP_BIT]
         && (status_reg[`WWDR_ST_IRQ_BIT] || !$past(ctrl_reg.irq_enable)))
      else $error("Compare match flags not set");

   a_reload_top: assert property (
      (pend_reg && sync_cnt_reg == 2'h2 && wdog_tick_i) |=> cnt_reg == `WWDR_CNT_TOP && !pend_reg)
      else $error("Reload not done on third watchdog clock");

   a_zero_reset: assert property (
      (step && cnt_reg == `WWDR_CNT_LAST) |=> sys_reset_req_o && cnt_reg == `WWDR_CNT_ZERO)
      else $error("Reaching zero did not request reset");

   a_irq_level: assert property (
      irq_o == |(status_reg & mask_reg))
      else $error("Interrupt output disagrees with status and mask");

   a_rdata_idle: assert property (
      !bus_req_i.re |=> rdata_o == 32'h00000000)
      else $error("Read data not zero outside the read cycle");

   a_irq_flag_gated: assert property (
      (hit_cmp && !ctrl_reg.irq_enable && !status_reg[`WWDR_ST_IRQ_BIT])
      |=> !status_reg[`WWDR_ST_IRQ_BIT])
      else $error("Interrupt flag set with interrupts disabled");

   a_zero_holds: assert property (
      (cnt_reg == `WWDR_CNT_ZERO && !reload_now) |=> cnt_reg == `WWDR_CNT_ZERO)
      else $error("Counter left zero without a reload");

   a_reset_sticky: assert property (
      sys_reset_req_o |=> sys_reset_req_o)
      else $error("Reset request dropped before chip reset");

   a_key_while_disabled: assert property (
      (key_ok && !ctrl_reg.counter_enable && !pend_reg) |=> !pend_reg)
      else $error("Key accepted while counter disabled");

   a_hold_disabled: assert property (
      (!ctrl_reg.counter_enable && !reload_now) |=> $stable(cnt_reg))
      else $error("Counter moved while disabled");

   c_valid_reload: cover property (key_accept ##[1:20] reload_now);
   c_early_reset: cover property (key_early ##1 sys_reset_req_o);
   c_cmp_irq: cover property (hit_cmp ##1 irq_o);
   c_halt_freeze: cover property (frozen && wdog_tick_i && ctrl_reg.counter_enable);
   c_expiry: cover property (step && cnt_reg == `WWDR_CNT_LAST);

endmodule // wwdr_window_watchdog_regs

// ===== wwdr_window_watchdog_regs_tb_top.sv
`timescale 1ns/1ps
`include "wwdr_params.svh"

module wwdr_window_watchdog_regs_tb_top;
   typedef struct {
      logic [3:0] psc;
      int ticks;
      logic [5:0] cnt;
   } wwdr_row_t;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wwdr_pkg::wwdr_bus_req_t bus_req_i = '0;
   logic [31:0] rdata_o;
   logic wdog_tick_i = 1'b0;
   logic cpu_halted_i = 1'b0;
   logic irq_o;
   logic sys_reset_req_o;
   int n_errors = 0;
   int comparisons = 0;
   // One tick short of six periods, so a prescaler that wraps early shows
   wwdr_row_t rows[8] = '{
      '{4'h0, 5, 6'h3A}, '{4'h1, 11, 6'h3A}, '{4'h2, 23, 6'h3A}, '{4'h3, 47, 6'h3A},
      '{4'h4, 95, 6'h3A}, '{4'h5, 191, 6'h3A}, '{4'h6, 383, 6'h3A}, '{4'h7, 767, 6'h3A}};
   logic [31:0] ctrl;

   always #2.5 clk_i = ~clk_i;

   wwdr_window_watchdog_regs dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus_req_i(bus_req_i),
      .rdata_o(rdata_o),
      .wdog_tick_i(wdog_tick_i),
      .cpu_halted_i(cpu_halted_i),
      .irq_o(irq_o),
      .sys_reset_req_o(sys_reset_req_o)
   );

   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus_req_i.we <= 1'b1;
      bus_req_i.addr <= a;
      bus_req_i.wdata <= d;
      @(posedge clk_i);
      bus_req_i.we <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
      @(posedge clk_i);
      bus_req_i.re <= 1'b1;
      bus_req_i.addr <= a;
      @(posedge clk_i);
      bus_req_i.re <= 1'b0;
      #1 chk_word(name, exp, rdata_o);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_i);
         wdog_tick_i <= 1'b1;
      end
      @(posedge clk_i);
      wdog_tick_i <= 1'b0;
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   task automatic finish_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // The longest row needs under 1000 cycles; this leaves ample margin
   initial begin
      #200000;
      n_errors++;
      finish_test();
   end

   initial begin
      do_reset();
      rd(8'h04, "ctrl reset", `WWDR_CTRL_RESET);
      rd(8'h0C, "count reset", 32'h0000003F);
      rd(8'h00, "reload read", 32'h00000000);
      rd(8'h08, "status reset", 32'h00000000);
      rd(8'h10, "mask reset", 32'h00000000);
      wr(8'h14, 32'hFFFFFFFF);
      rd(8'h14, "unmapped", 32'h00000000);
      foreach (rows[i]) begin
         do_reset();
         ctrl = 32'h00200001 | {20'h00000, rows[i].psc, 8'h00};
         wr(8'h04, ctrl);
         wr(8'h04, 32'h00000000);
         rd(8'h04, "ctrl lock", ctrl);
         tick(rows[i].ticks);
         rd(8'h0C, "count step", {26'h0000000, rows[i].cnt});
      end
      // Window reload, counting on through a debug halt
      do_reset();
      wr(8'h04, 32'h80100003);
      cpu_halted_i <= 1'b1;
      tick(47);
      rd(8'h0C, "count at compare", 32'h00000010);
      rd(8'h08, "flags set", 32'h00000005);
      chk_bit("irq masked", 1'b0, irq_o);
      wr(8'h10, 32'h00000005);
      #1 chk_bit("irq unmasked", 1'b1, irq_o);
      wr(8'h00, 32'h00005AA4);
      rd(8'h0C, "wrong key", 32'h00000010);
      wr(8'h00, `WWDR_RELOAD_KEY);
      tick(2);
      rd(8'h0C, "reload pending", 32'h0000000E);
      tick(1);
      rd(8'h0C, "reloaded", 32'h0000003F);
      chk_bit("no reset in window", 1'b0, sys_reset_req_o);
      wr(8'h08, 32'h00000005);
      #1 chk_bit("irq cleared", 1'b0, irq_o);
      rd(8'h08, "flags cleared", 32'h00000000);
      @(posedge clk_i);
      cpu_halted_i <= 1'b0;
      // Frozen while halted, then a key above the window
      do_reset();
      wr(8'h04, 32'h00010001);
      cpu_halted_i <= 1'b1;
      tick(4);
      cpu_halted_i <= 1'b0;
      rd(8'h0C, "frozen", 32'h0000003F);
      tick(2);
      rd(8'h0C, "resumed", 32'h0000003D);
      chk_bit("no early reset", 1'b0, sys_reset_req_o);
      wr(8'h00, `WWDR_RELOAD_KEY);
      @(posedge clk_i);
      #1 chk_bit("early key reset", 1'b1, sys_reset_req_o);
      // Expiry without a reload
      do_reset();
      wr(8'h00, `WWDR_RELOAD_KEY);
      wr(8'h04, 32'h00000001);
      tick(62);
      #1 chk_bit("before expiry", 1'b0, sys_reset_req_o);
      tick(1);
      @(posedge clk_i);
      #1 chk_bit("expiry reset", 1'b1, sys_reset_req_o);
      rd(8'h0C, "count at zero", 32'h00000000);
      rd(8'h08, "flags no irq", 32'h00000004);
      finish_test();
   end
endmodule // wwdr_window_watchdog_regs_tb_top
